// ==== logic/pol_fault_protection_logic.sv ====
// Protection supervisor of a digital step-down POL converter.
// Assumes measurements and phase inputs come from logic on ref_clk;
// only the supply-good pin arrives from outside and is synchronised.
`timescale 1ns/10ps
// Function
// [R01] Warn flag low above 120 degC
// [R02] Warn flag restores below 117 degC
// [R03] Warnings never turn output off
// [R04] PG window 105/110 high, 90/95 low
// [R05] PG after steady, delayed 0-150 ms
// [R06] PG checked during margining, scaled
// [R07] Outside window pin low, flag 0
// [R08] External low pin gives PG warning
// [R09] PG low at command or ramp-down
// [R10] Overcurrent above prebias: critical off
// [R11] Current limit temp compensation disable
// [R12] Steady undervoltage without OC: sequenced
// [R13] Above 130 degC: sequenced off
// [R14] Non-latching OT restarts below 120
// [R15] Ramp-up tracking over 250 mV: critical
// [R16] Tracking disable bit in config one
// [R17] Margining never re-enables tracking
// [R18] Limits held as setpoint percentages
// [R19] Overvoltage above prebias: emergency off
// [R20] OV 110-130 %, >=0.5 V, >=Vset+0.25
// [R21] Software keeps load-regulation bits intact
// [R22] Fall rate chosen apart from rise
// [R23] Non-latching retries every 130 ms
// [R24] Latching stays off until released
// [R25] Compare per sample, flags reset high
module pol_fault_protection_logic
	import pol_prot_pkg::*;
#(
	parameter int CYC_MS = CYC_PER_MS // Clock cycles per millisecond
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire wb_req_t     wbReq,
	output logic [31:0]      wbDatR,
	output logic             wbAck,
	input  wire meas_t       meas,
	input  wire logic        sampleValid,
	input  wire phase_t      phase,
	input  wire logic        pgPinIn,
	output logic             pgPinOut,
	output logic             pgPinOe,
	output logic             runEnable,
	output off_mode_t        offMode,
	output logic [2:0]       loadRegSel,
	output logic [3:0]       riseRate,
	output logic [3:0]       fallRate
);
	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (CYC_MS < 2 || CYC_MS > 65536) begin : g_bad
		$error("CYC_MS out of range");
	end

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		prot_state_t state;     // Supervisor state
		off_mode_t   off;       // Active turn-off style
		logic        run;       // Converter allowed to run
		logic        ack;       // Bus acknowledge
		logic [31:0] rdat;      // Read data
		logic        trDis;     // Tracking protection off
		logic [4:0]  latchSel;  // Latching per ov,tr,ot,uv,oc
		logic        pgOffRamp; // PG low at ramp-down, else at cmd
		logic        pgHiSel;   // 1 selects 110 %
		logic        pgLoSel;   // 1 selects 95 %
		logic [7:0]  uvPct;     // UV threshold, percent
		logic [7:0]  ovPct;     // OV threshold, percent
		logic [15:0] ocMa;      // OC threshold, mA
		logic        tcDis;     // Temp compensation off
		logic [2:0]  loadReg;   // Load regulation choice
		logic [7:0]  pgDly;     // PG release delay, ms
		logic [3:0]  rise;      // Rising rate code
		logic [3:0]  fall;      // Falling rate code
		flags_t      flags;     // Active-low status
		logic [4:0]  cause;     // Trip cause ov,tr,ot,uv,oc
		logic        latch;     // Trip is latching
		cond_t       cond;      // Sampled comparisons
		logic [15:0] msCnt;     // Millisecond divider
		logic [7:0]  retry;     // Hiccup countdown, ms
		logic [7:0]  pgCnt;     // PG delay count, ms
		logic        pgRel;     // PG checking released
		logic        pgOe;      // Pin pulled low
		logic [1:0]  oeHist;    // Drive history vs sync lag
		logic        sync1;     // Pin synchroniser, first
		logic        sync2;     // Pin synchroniser, second
	} st_t;

	st_t r;      // Registered state
	st_t n;      // Next state

	// ----------------------------------------------------------------
	// Comparators on the live measurement
	// ----------------------------------------------------------------
	logic [23:0] vPct;    // Vout times 100
	logic [23:0] uvLvl;   // Setpoint times UV percent
	logic [23:0] ovLvl;   // Setpoint times OV percent
	logic [23:0] hiLvl;   // Setpoint times PG high percent
	logic [23:0] loLvl;   // Setpoint times PG low percent
	logic        aboveBias; // Output above any prebias
	logic [7:0]  tOver;   // Degrees above room
	logic [16:0] ocEff;   // Compensated OC threshold
	logic [15:0] trDiff;  // Tracking error magnitude
	cond_t       cNow;    // Live comparison set

	// Percent levels scale with setpoint, margining included
	assign vPct  = 24'(meas.vout) * 24'h000064; // R18
	assign uvLvl = 24'(meas.setpoint) * 24'(r.uvPct);
	assign ovLvl = 24'(meas.setpoint) * 24'(r.ovPct);
	assign hiLvl = 24'(meas.setpoint) *
		24'(r.pgHiSel ? PG_HI_HI : PG_HI_LO); // R04
	assign loLvl = 24'(meas.setpoint) *
		24'(r.pgLoSel ? PG_LO_HI : PG_LO_LO); // R04
	assign aboveBias = meas.vout > meas.prebias;
	// Copper TC raises the trip point above room unless disabled
	assign tOver = (meas.tempC > TEMP_ROOM_C) ?
		8'(meas.tempC - TEMP_ROOM_C) : 8'h00;
	assign ocEff = {1'b0, r.ocMa} +
		(r.tcDis ? 17'h00000 : 17'(tOver) * OC_COMP_MA); // R11
	assign trDiff = (meas.vout >= meas.rampTarget) ?
		meas.vout - meas.rampTarget : meas.rampTarget - meas.vout;

	always_comb begin
		cNow.oc = aboveBias && ({1'b0, meas.iout} >= ocEff); // R10
		cNow.uv = phase.steady && (vPct < uvLvl) && !cNow.oc; // R12
		cNow.ot = meas.tempC > TEMP_OT_C; // R13
		// Margin moves never count as a ramp for tracking
		cNow.tr = phase.rampingUp && !phase.marginMove && // R17
			!r.trDis && (trDiff > TRACK_MV); // R15 R16
		// Trip above the largest of the three OV floors
		cNow.ov = aboveBias && (vPct > ovLvl) && // R19
			(meas.vout > OV_MIN_MV) && // R20
			({1'b0, meas.vout} >
			{1'b0, meas.setpoint} + {1'b0, OV_ABOVE_MV}); // R20
		cNow.pgBad = (vPct > hiLvl) || (vPct < loLvl); // R07
		cNow.hot = meas.tempC > TEMP_WARN_C; // R01
		cNow.below = meas.tempC < TEMP_CLR_C; // R02
		cNow.cool = meas.tempC < TEMP_WARN_C; // R14
	end

	// ----------------------------------------------------------------
	// Register readback and bus decode
	// ----------------------------------------------------------------
	logic [31:0] rdWord;  // Word at the addressed offset
	logic [31:0] wMask;   // Byte-lane mask
	logic [31:0] wWord;   // Merged write word
	logic        busWr;   // Write takes effect this edge
	logic [4:0]  faultNow; // Sampled faults ov,tr,ot,uv,oc

	always_comb begin
		unique case (wbReq.adr)
			ADR_CFG_ONE: rdWord = {25'h0, r.pgOffRamp, r.latchSel, r.trDis};
			ADR_THR: rdWord = {8'h00, r.ovPct, r.uvPct,
				6'h00, r.pgLoSel, r.pgHiSel};
			ADR_CLIM: rdWord = {12'h000, r.loadReg, r.tcDis, r.ocMa};
			ADR_PGDLY: rdWord = {24'h000000, r.pgDly};
			ADR_FLAGS: rdWord = {21'h000000, r.state, 1'b0, r.flags};
			ADR_RAMP: rdWord = {24'h000000, r.fall, r.rise};
			default: rdWord = 32'h00000000; // Unmapped reads zero
		endcase
	end

	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign wMask[8*b +: 8] = {8{wbReq.sel[b]}};
	end
	assign wWord = (rdWord & ~wMask) | (wbReq.dat & wMask);
	assign busWr = wbReq.cyc && wbReq.stb && wbReq.we && r.ack;
	assign faultNow = {r.cond.ov, r.cond.tr, r.cond.ot,
		r.cond.uv, r.cond.oc};

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic msTick;    // One-ms strobe
		logic offLow;    // Turn-off pulls PG low
		logic extLow;    // Someone else holds the pin low
		logic [4:0] clr; // Software release of fault flags
		msTick = 1'b0;
		offLow = 1'b0;
		extLow = 1'b0;
		clr    = 5'h00;
		n = r;
		// Millisecond timebase shared by PG delay and hiccup
		msTick = (r.msCnt == 16'(CYC_MS - 1));
		n.msCnt = msTick ? 16'h0000 : r.msCnt + 16'h0001;
		// Two-stage pin synchroniser
		n.sync1 = pgPinIn;
		n.sync2 = r.sync1;
		// Comparisons advance only on a fresh sample
		if (sampleValid) begin
			n.cond = cNow; // R25
		end

		// Classic Wishbone: one wait state, ack for one cycle
		n.ack = wbReq.cyc && wbReq.stb && !r.ack;
		if (wbReq.cyc && wbReq.stb && !r.ack) begin
			n.rdat = rdWord;
		end
		if (busWr) begin
			unique case (wbReq.adr)
				ADR_CFG_ONE: begin
					n.trDis = wWord[0]; // R16
					n.latchSel = wWord[5:1];
					n.pgOffRamp = wWord[6]; // R09
				end
				ADR_THR: begin
					n.pgHiSel = wWord[0];
					n.pgLoSel = wWord[1];
					n.uvPct = wWord[15:8];
					// Clamp OV percent into its legal span
					if (wWord[23:16] < OV_PCT_MIN) begin
						n.ovPct = OV_PCT_MIN; // R20
					end else if (wWord[23:16] > OV_PCT_MAX) begin
						n.ovPct = OV_PCT_MAX; // R20
					end else begin
						n.ovPct = wWord[23:16];
					end
				end
				ADR_CLIM: begin
					// Byte lanes let software leave regulation alone
					n.ocMa = wWord[15:0];
					n.tcDis = wWord[16]; // R11
					n.loadReg = wWord[19:17]; // R21
				end
				ADR_PGDLY: begin
					n.pgDly = (wWord[7:0] > 8'(PG_DELAY_MAX)) ?
						8'(PG_DELAY_MAX) : wWord[7:0]; // R05
				end
				ADR_FLAGS: begin
					// Write 1 releases a fault flag once cause is gone
					clr = wWord[6:2] & ~faultNow; // R24
				end
				ADR_RAMP: begin
					n.rise = wWord[3:0];
					n.fall = wWord[7:4]; // R22
				end
				default: begin
					// Unmapped writes are acknowledged and dropped
				end
			endcase
		end
		n.flags.oc = r.flags.oc | clr[0];
		n.flags.uv = r.flags.uv | clr[1];
		n.flags.ot = r.flags.ot | clr[2];
		n.flags.tr = r.flags.tr | clr[3];
		n.flags.ov = r.flags.ov | clr[4];

		// Temperature warning with 3 degC hysteresis
		if (r.cond.hot) begin
			n.flags.tw = 1'b0; // R01
		end else if (r.cond.below) begin
			n.flags.tw = 1'b1; // R02
		end

		// Supply-good release delay counts from steady state
		if (!phase.steady) begin
			n.pgCnt = 8'h00;
			n.pgRel = 1'b0;
		end else if (!r.pgRel) begin
			if (r.pgCnt >= r.pgDly) begin
				n.pgRel = 1'b1; // R05
			end else if (msTick) begin
				n.pgCnt = r.pgCnt + 8'h01;
			end
		end
		offLow = r.pgOffRamp ? phase.rampingDown : !phase.onCmd; // R09
		// Steady stays high through margin moves, so checking goes on
		n.pgOe = !r.pgRel || (r.cond.pgBad && r.pgRel) || // R06 R07
			offLow;
		// Sync lag would fake a low after release; wait it out
		n.oeHist = {r.oeHist[0], r.pgOe};
		extLow = !r.sync2 && !r.pgOe && (r.oeHist == 2'b00); // R08
		n.flags.pg = !((r.pgRel && r.cond.pgBad) || extLow); // R07 R08

		// Supervisor: only faults trip, warnings stay advisory
		unique case (r.state)
			S_RUN: begin
				if (|faultNow) begin // R03
					n.state = S_HICCUP;
					n.cause = faultNow;
					n.latch = |(faultNow & r.latchSel);
					n.retry = 8'(RETRY_MS);
					if (r.cond.ov) begin
						n.off = OFF_EMERG; // R19
					end else if (r.cond.oc || r.cond.tr) begin
						n.off = OFF_CRIT; // R10 R15
					end else begin
						n.off = OFF_SEQ; // R12 R13
					end
				end
			end
			S_HICCUP: begin
				if (msTick && r.retry != 8'h00) begin
					n.retry = r.retry - 8'h01;
				end
				if (!r.latch && r.cause == 5'h04 && r.cond.cool) begin
					n.state = S_RUN; // R14
					n.off = OFF_NONE;
				end else if (r.retry == 8'h00) begin
					if (r.latch) begin
						n.state = S_LATCHED; // R24
					end else begin
						// Retry; a lasting cause trips it again
						n.state = S_RUN; // R23
						n.off = OFF_NONE;
					end
				end
			end
			S_LATCHED: begin
				if (!phase.onCmd ||
					({n.flags.ov, n.flags.tr, n.flags.ot,
					n.flags.uv, n.flags.oc} & r.cause) == r.cause) begin
					n.state = S_RUN; // R24
					n.off = OFF_NONE;
				end
			end
		endcase
		// Fault flags go low on trip; a set beats a clear
		if (r.state == S_RUN) begin
			n.flags.oc = n.flags.oc & !r.cond.oc; // R10
			n.flags.uv = n.flags.uv & !r.cond.uv; // R12
			n.flags.ot = n.flags.ot & !r.cond.ot; // R13
			n.flags.tr = n.flags.tr & !r.cond.tr; // R15
			n.flags.ov = n.flags.ov & !r.cond.ov; // R19
		end
		// Non-latching restart restores the cause flags
		if (r.state == S_HICCUP && n.state == S_RUN) begin
			n.flags.oc = r.flags.oc | r.cause[0];
			n.flags.uv = r.flags.uv | r.cause[1];
			n.flags.ot = r.flags.ot | r.cause[2];
			n.flags.tr = r.flags.tr | r.cause[3];
			n.flags.ov = r.flags.ov | r.cause[4];
		end
		n.run = (n.state == S_RUN) && phase.onCmd;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
			r.state <= S_RUN;
			r.off <= OFF_NONE;
			r.uvPct <= UV_PCT_RST;
			r.ovPct <= OV_PCT_RST;
			r.ocMa <= OC_MA_RST;
			r.pgDly <= PGDLY_RST;
			r.flags <= 7'h7F; // R25
			r.pgOe <= 1'b1;
			r.oeHist <= 2'b11;
			r.sync1 <= 1'b1;
			r.sync2 <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign wbDatR = r.rdat;
	assign wbAck = r.ack;
	assign pgPinOut = 1'b0; // Open collector only pulls low
	assign pgPinOe = r.pgOe;
	assign runEnable = r.run;
	assign offMode = r.off;
	assign loadRegSel = r.loadReg;
	assign riseRate = r.rise;
	assign fallRate = r.fall;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	chk_ov_emerg_off: assert property ( // R19
		r.state == S_RUN && r.cond.ov |=> offMode == OFF_EMERG && !runEnable
	) else $error("OV did not give emergency off");
	chk_oc_crit_off: assert property ( // R10
		r.state == S_RUN && r.cond.oc && !r.cond.ov
		|=> offMode == OFF_CRIT && !r.flags.oc
	) else $error("OC did not give critical off");
	chk_ot_seq_off: assert property ( // R13
		r.state == S_RUN && faultNow == 5'h04 |=> offMode == OFF_SEQ
	) else $error("OT did not give sequenced off");
	chk_warn_set: assert property ( // R01
		r.cond.hot |=> !r.flags.tw
	) else $error("Temp warning not raised");
	chk_warn_hold: assert property ( // R02
		!r.flags.tw && !r.cond.below |=> !r.flags.tw
	) else $error("Temp warning cleared early");
	chk_warn_no_off: assert property ( // R03
		r.state == S_RUN && faultNow == 5'h00 && phase.onCmd |=> runEnable
	) else $error("Warning shut the output");
	chk_pg_window: assert property ( // R07
		r.pgRel && r.cond.pgBad |=> pgPinOe && !r.flags.pg
	) else $error("PG not pulled low outside window");
	chk_track_mask: assert property ( // R16
		sampleValid && r.trDis |=> !r.cond.tr
	) else $error("Tracking trip while disabled");
	chk_latch_hold: assert property ( // R24
		r.state == S_LATCHED && phase.onCmd && r.flags.ov == 1'b0
		&& r.cause[4] && !busWr |=> r.state == S_LATCHED
	) else $error("Latched trip released early");
	chk_bus_ack: assert property (
		wbAck |=> !wbAck
	) else $error("Ack held longer than one cycle");

	cov_hiccup: cover property (r.state == S_HICCUP ##1 r.state == S_RUN);
	cov_latched: cover property (r.state == S_LATCHED);
	cov_pg_release: cover property ($rose(r.pgRel) ##1 !pgPinOe);
	cov_ext_low: cover property ($fell(r.flags.pg) && !r.cond.pgBad);
endmodule : pol_fault_protection_logic

// ==== logic/pol_prot_pkg.sv ====
// Constants, register map and carrier types of the POL protection block.
// Assumes one 40 MHz controller clock and a classic Wishbone master.
package pol_prot_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 40000000;      // Controller clock
	localparam int CYC_PER_MS    = CLK_HZ / 1000; // Default ms divider
	localparam int RETRY_MS      = 130;           // Hiccup interval, ms
	localparam int PG_DELAY_MAX  = 150;           // Longest PG delay, ms
	// ----------------------------------------------------------------
	// Thresholds (mV, mA, degC, percent)
	// ----------------------------------------------------------------
	// Unsigned degC: a signed byte cannot hold the 130 degC trip point
	localparam logic [7:0] TEMP_WARN_C = 8'h78; // 120 degC
	localparam logic [7:0] TEMP_CLR_C  = 8'h75; // 117 degC
	localparam logic [7:0] TEMP_OT_C   = 8'h82; // 130 degC
	localparam logic [7:0] TEMP_ROOM_C = 8'h19; // 25 degC
	localparam logic [15:0] TRACK_MV    = 16'h00FA;   // 250 mV
	localparam logic [15:0] OV_MIN_MV   = 16'h01F4;   // 500 mV
	localparam logic [15:0] OV_ABOVE_MV = 16'h00FA;   // 250 mV
	localparam logic [7:0]  OV_PCT_MIN  = 8'h6E;      // 110 %
	localparam logic [7:0]  OV_PCT_MAX  = 8'h82;      // 130 %
	localparam logic [7:0]  PG_HI_LO    = 8'h69;      // 105 %
	localparam logic [7:0]  PG_HI_HI    = 8'h6E;      // 110 %
	localparam logic [7:0]  PG_LO_LO    = 8'h5A;      // 90 %
	localparam logic [7:0]  PG_LO_HI    = 8'h5F;      // 95 %
	localparam logic [16:0] OC_COMP_MA  = 17'h00008;  // mA per degC
	// ----------------------------------------------------------------
	// Register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_CFG_ONE = 8'h00; // fault_config_one
	localparam logic [7:0] ADR_THR     = 8'h04; // threshold_config
	localparam logic [7:0] ADR_CLIM    = 8'h08; // current_limit_reg
	localparam logic [7:0] ADR_PGDLY   = 8'h0C; // PG release delay
	localparam logic [7:0] ADR_FLAGS   = 8'h10; // fault_flag_reg
	localparam logic [7:0] ADR_RAMP    = 8'h14; // Ramp rate select
	localparam logic [7:0]  UV_PCT_RST = 8'h55; // 85 %
	localparam logic [7:0]  OV_PCT_RST = 8'h78; // 120 %
	localparam logic [15:0] OC_MA_RST  = 16'h2EE0;
	localparam logic [7:0]  PGDLY_RST  = 8'h00;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		S_RUN     = 3'h1,
		S_HICCUP  = 3'h2,
		S_LATCHED = 3'h4
	} prot_state_t;
	typedef enum logic [1:0] {
		OFF_NONE = 2'h0, OFF_SEQ = 2'h1, OFF_CRIT = 2'h2, OFF_EMERG = 2'h3
	} off_mode_t;
	typedef struct packed { // Active low, bit 0 is temp warning
		logic ov, tr, ot, uv, oc, pg, tw;
	} flags_t;
	typedef struct packed {
		logic       cyc, stb, we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;
	typedef struct packed {
		logic [15:0]       vout, iout, setpoint, rampTarget, prebias;
		logic [7:0]        tempC; // degC, below zero arrives as 0
	} meas_t;
	typedef struct packed {
		logic onCmd, rampingUp, steady, marginMove, rampingDown;
	} phase_t;
	typedef struct packed { // Sampled comparator results
		logic ov, tr, ot, uv, oc, pgBad, hot, below, cool;
	} cond_t;
endpackage : pol_prot_pkg

// ==== test/pol_mgr_model.sv ====
// Power manager model: a classic Wishbone master for the POL block.
// Assumes a registered ack that follows the request.
`timescale 1ns/10ps
module pol_mgr_model
	import pol_prot_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        wbAck,
	input  wire logic [31:0] wbDatR,
	output wb_req_t          wbReq
);
	// ----------------------------------------------------------------
	// Bus cycle
	// ----------------------------------------------------------------
	initial wbReq = '0; // Idle bus from time zero
	// Request held until ack is seen high on a falling edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		wbReq <= '{1'b1, 1'b1, w, a, 4'hF, d};
		// No limit here; the bench watchdog ends a hung cycle
		do begin
			@(negedge ref_clk);
		end while (wbAck !== 1'b1);
		@(posedge ref_clk);
		q = wbDatR; // Taken at the ack edge only
		wbReq <= '0; // Release leaves one idle cycle
	endtask : xfer
endmodule : pol_mgr_model

// ==== test/test_pol_fault_protection_logic.sv ====
// Self-checking bench of the POL protection supervisor.
// Assumes the manager model as bus master and a pulled-up PG wire.
`timescale 1ns/10ps
module test_pol_fault_protection_logic
	import pol_prot_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int CM  = 10;            // Short ms keeps the run brief
	localparam int HIC = RETRY_MS * CM; // Hiccup span in cycles
	localparam phase_t PON = 5'b10000;  // On, not yet steady
	localparam phase_t PST = 5'b10100;  // Steady
	localparam phase_t PUP = 5'b11000;  // Ramping up
	localparam phase_t PMG = 5'b11010;  // Ramp from margining
	localparam phase_t PMS = 5'b10110;  // Steady, margining
	logic        ref_clk = 1'b0;
	logic        rst_b   = 1'b0;
	wb_req_t     wbReq;
	logic [31:0] wbDatR;
	logic        wbAck;
	meas_t       meas;
	logic        sampleValid;
	phase_t      phase;
	logic        extLow;      // Outside circuit pulling PG low
	logic        pgPinOut;
	logic        pgPinOe;
	logic        runEnable;
	off_mode_t   offMode;
	logic [2:0]  loadRegSel;
	logic [3:0]  riseRate;
	logic [3:0]  fallRate;
	logic [31:0] q;           // Last read word
	int          fails;
	int          compares;
	wire logic   pgWire = !(pgPinOe | extLow); // Pull-up wins when free
	always #12.5 ref_clk = ~ref_clk;
	pol_fault_protection_logic #(.CYC_MS(CM)) i_pol_fault_protection_logic (
		.ref_clk(ref_clk), .rst_b(rst_b), .wbReq(wbReq), .wbDatR(wbDatR),
		.wbAck(wbAck), .meas(meas), .sampleValid(sampleValid),
		.phase(phase), .pgPinIn(pgWire), .pgPinOut(pgPinOut),
		.pgPinOe(pgPinOe), .runEnable(runEnable), .offMode(offMode),
		.loadRegSel(loadRegSel), .riseRate(riseRate), .fallRate(fallRate));
	pol_mgr_model i_pol_mgr_model (.ref_clk(ref_clk), .wbAck(wbAck),
		.wbDatR(wbDatR), .wbReq(wbReq));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_pol_mgr_model.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		i_pol_mgr_model.xfer(1'b0, a, 32'h0, q);
	endtask : rd
	// One new sample, then settle and look at the falling edge
	task automatic smp(input logic [15:0] v, i, input logic [7:0] t,
		input phase_t ph, input logic [15:0] sp = 16'd1000,
		input logic [15:0] rt = 16'd1000);
		@(posedge ref_clk);
		meas <= '{v, i, sp, rt, 16'd0, t};
		phase <= ph;
		sampleValid <= 1'b1;
		@(posedge ref_clk);
		sampleValid <= 1'b0;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : smp
	task automatic waitRun(input string nm);
		int n;
		n = 0;
		while (runEnable !== 1'b1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		chk(nm, runEnable, 1'b1);
	endtask : waitRun
	// Trip, check off style and flag, clear, then wait for the restart
	task automatic trip(input string nm, input logic [15:0] v, i, rt,
		input logic [7:0] t, input phase_t ph, input off_mode_t m,
		input int b, input bit quick);
		smp(v, i, t, ph, 16'd1000, rt);
		chk(nm, offMode, m);
		chk(nm, runEnable, 1'b0);
		rd(ADR_FLAGS);
		chk(nm, q[b], 1'b0);
		smp(16'd1000, 16'd1000, quick ? 8'sd119 : 8'sd25, PST);
		if (!quick) begin
			repeat (HIC - 200) @(negedge ref_clk);
			chk(nm, runEnable, 1'b0); // No early retry
		end
		waitRun(nm);
		$display("test %s done", nm);
	endtask : trip
	task automatic complete_run;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		fails = 0;
		compares = 0;
		meas = '{16'd1000, 16'd1000, 16'd1000, 16'd1000, 16'd0, 8'sd25};
		sampleValid = 1'b0;
		phase = PON;
		extLow = 1'b0;
		repeat (12) @(posedge ref_clk);
		chk("run in reset", runEnable, 1'b0);
		rst_b <= 1'b1;
		rd(ADR_FLAGS);
		chk("flags reset", q, 32'h17F);
		rd(ADR_THR);
		chk("thr reset", q, {8'h0, OV_PCT_RST, UV_PCT_RST, 8'h0});
		rd(ADR_CLIM);
		chk("clim reset", q, {16'h0, OC_MA_RST});
		rd(8'h20);
		chk("unmapped", q, 32'h0);
		wr(ADR_THR, 32'h00C85500);
		rd(ADR_THR);
		chk("ov clamp hi", q[23:16], OV_PCT_MAX);
		wr(ADR_THR, 32'h00505500);
		rd(ADR_THR);
		chk("ov clamp lo", q[23:16], OV_PCT_MIN);
		wr(ADR_THR, 32'h00785500);
		wr(ADR_RAMP, 32'hA5);
		repeat (2) @(negedge ref_clk);
		chk("rise", riseRate, 4'h5);
		chk("fall", fallRate, 4'hA);
		wr(ADR_CLIM, 32'h00062EE0);
		rd(ADR_CLIM);
		wr(ADR_CLIM, q | 32'h10000);
		rd(ADR_CLIM);
		chk("comp off", q[16], 1'b1);
		chk("load reg", loadRegSel, 3'h3);
		wr(ADR_PGDLY, 32'hFF);
		rd(ADR_PGDLY);
		chk("pg delay clamp", q, 32'(PG_DELAY_MAX));
		wr(ADR_PGDLY, 32'h2);
		$display("test registers done");
		smp(16'd1000, 16'd1000, 8'sd25, PST);
		chk("pg delay", pgPinOe, 1'b1);
		repeat (3 * CM) @(negedge ref_clk);
		chk("pg inside", pgPinOe, 1'b0);
		smp(16'd1080, 16'd1000, 8'sd25, PST);
		chk("pg above", pgPinOe, 1'b1);
		chk("pg drive", pgPinOut, 1'b0);
		rd(ADR_FLAGS);
		chk("pg flag", q[1], 1'b0);
		wr(ADR_THR, 32'h00785501);
		smp(16'd1080, 16'd1000, 8'sd25, PST);
		chk("pg 110", pgPinOe, 1'b0);
		smp(16'd1080, 16'd1000, 8'sd25, PMS, 16'd1250);
		chk("pg margin", pgPinOe, 1'b1);
		smp(16'd1000, 16'd1000, 8'sd25, PST);
		@(posedge ref_clk);
		extLow <= 1'b1;
		repeat (8) @(negedge ref_clk);
		rd(ADR_FLAGS);
		extLow <= 1'b0;
		chk("pg external", q[1], 1'b0);
		$display("test supply good done");
		smp(16'd1000, 16'd1000, 8'sd121, PST);
		rd(ADR_FLAGS);
		chk("warn set", q[0], 1'b0);
		chk("warn run", runEnable, 1'b1);
		smp(16'd1000, 16'd1000, 8'sd118, PST);
		rd(ADR_FLAGS);
		chk("warn hold", q[0], 1'b0);
		smp(16'd1000, 16'd1000, 8'sd116, PST);
		rd(ADR_FLAGS);
		chk("warn clear", q[0], 1'b1);
		$display("test warning done");
		trip("oc", 16'd1000, 16'd13000, 16'd1000, 8'd25, PST,
			OFF_CRIT, 2, 1'b0);
		trip("uv", 16'd800, 16'd1000, 16'd1000, 8'd25, PST,
			OFF_SEQ, 3, 1'b0);
		trip("ot", 16'd1000, 16'd1000, 16'd1000, 8'd131, PST,
			OFF_SEQ, 4, 1'b1);
		trip("tr", 16'd1000, 16'd1000, 16'd700, 8'd25, PUP,
			OFF_CRIT, 5, 1'b0);
		trip("ov", 16'd1300, 16'd1000, 16'd1000, 8'd25, PST,
			OFF_EMERG, 6, 1'b0);
		smp(16'd1000, 16'd1000, 8'sd25, PMG, 16'd1000, 16'd700);
		chk("margin ramp", runEnable, 1'b1);
		wr(ADR_CFG_ONE, 32'h1);
		smp(16'd1000, 16'd1000, 8'sd25, PUP, 16'd1000, 16'd700);
		chk("track off", runEnable, 1'b1);
		wr(ADR_CFG_ONE, 32'h20);
		smp(16'd1300, 16'd1000, 8'sd25, PST);
		repeat (HIC + 50) @(negedge ref_clk);
		rd(ADR_FLAGS);
		chk("latched", q[10:8], 3'h4);
		smp(16'd1000, 16'd1000, 8'sd25, PST);
		chk("stay off", runEnable, 1'b0);
		wr(ADR_FLAGS, 32'h40);
		waitRun("latch release");
		$display("test latching done");
		wr(ADR_CFG_ONE, 32'h0);
		smp(16'd1000, 16'd1000, 8'sd25, PST);
		chk("pg before off", pgPinOe, 1'b0);
		smp(16'd1000, 16'd1000, 8'sd25, 5'b00100);
		chk("pg at off", pgPinOe, 1'b1);
		wr(ADR_CFG_ONE, 32'h40);
		smp(16'd1000, 16'd1000, 8'sd25, 5'b00100);
		chk("pg ramp wait", pgPinOe, 1'b0);
		smp(16'd1000, 16'd1000, 8'sd25, 5'b00101);
		chk("pg at ramp", pgPinOe, 1'b1);
		$display("test turn off done");
		complete_run;
	end
	initial begin
		#(25 * 40000);
		fails++;
		complete_run;
	end
endmodule : test_pol_fault_protection_logic
